// file: core/cwu_warmup_counter.sv
// Cascaded 16-bit warm-up counter that times oscillator stabilisation.
// Assumes control bytes come from software-written registers on clk_i and both
// oscillator clocks arrive as pins at no more than a quarter of clk_i.
// A source pin must stay high and low two clk_i cycles each or its edges are lost.
`timescale 1ns/1ns
`default_nettype none
`include "cwu_regs.svh"

module cwu_warmup_counter
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic low_freq_clock_i,
	input wire logic high_freq_clock_i,
	input wire logic [7:0] upper_timer_control_i,
	input wire logic [7:0] lower_timer_control_i,
	input wire logic [7:0] period_compare_high_i,
	input wire logic [7:0] period_compare_low_i,
	input wire logic [7:0] system_control_reg_two_i,
	output logic upper_timer_irq_o,
	output logic [15:0] count_o,
	output logic running_o,
	output cwu_pkg::cwu_src_t source_o,
	output logic sys_clk_low_sel_o,
	output logic low_osc_enable_o,
	output logic high_osc_enable_o,
	output logic upper_flipflop_init_o,
	output logic lower_flipflop_init_o
);
	import cwu_pkg::*;

	// Synchronised source edges
	logic slow_tick;
	logic fast_tick;

	// Decoded controls and the counting strobe
	logic run_bit;
	logic mode_ok;
	logic tick;
	logic match;
	cwu_src_t src_next;
	cwu_src_t src_reg;

	// Sequencer and counter datapath
	cwu_state_t state_reg;
	cwu_state_t state_next;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic irq_reg;
	logic running_reg;

	// Captured control bytes
	logic [7:0] sys_reg;
	logic [7:0] upper_reg;
	logic [7:0] lower_reg;

	// Source edges, each pin through its own synchroniser
	cwu_edge_sync u_slow_sync
	(
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.pin_i(low_freq_clock_i),
		.rise_o(slow_tick)
	);

	// Fast pin takes the same three-stage path, so it must run no faster than a quarter of clk_i
	cwu_edge_sync u_fast_sync
	(
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.pin_i(high_freq_clock_i),
		.rise_o(fast_tick)
	);

	// Timer control bytes captured once so all decode sees the same cycle
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			upper_reg <= `CWU_UPPER_CTRL_RESET;
			lower_reg <= `CWU_LOWER_CTRL_RESET;
		end
		else
		begin
			upper_reg <= upper_timer_control_i;
			lower_reg <= lower_timer_control_i;
		end
	end

	// System control byte; resets with the fast oscillator on and selected
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sys_reg <= `CWU_SYS_CTRL_RESET;
		else
			sys_reg <= system_control_reg_two_i;
	end

	// Source decode: slow for 43H, 4BH, C3H or CBH, fast for 63H, 6BH, E3H or EBH (bits 7 and 3 not decoded), anything else counts nothing
	always_comb
	begin
		// Refused codes leave the source at none, so a stray write cannot start counting
		src_next = CWU_SRC_NONE;
		if (lower_reg[`CWU_LOWER_MODE_MSB:`CWU_LOWER_MODE_LSB] == `CWU_LOWER_MODE_CASCADE)
		begin
			if (lower_reg[`CWU_LOWER_CLK_MSB:`CWU_LOWER_CLK_LSB] == `CWU_LOWER_CLK_SLOW)
				src_next = CWU_SRC_SLOW;
			else if (lower_reg[`CWU_LOWER_CLK_MSB:`CWU_LOWER_CLK_LSB] == `CWU_LOWER_CLK_FAST)
				src_next = CWU_SRC_FAST;
		end
	end

	// Registered source choice
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			src_reg <= CWU_SRC_NONE;
		else
			src_reg <= src_next;
	end

	// Warm-up mode and run decode
	assign mode_ok = (upper_reg[`CWU_UPPER_MODE_MSB:`CWU_UPPER_MODE_LSB] == `CWU_UPPER_MODE_WARMUP);
	assign run_bit = upper_reg[`CWU_UPPER_RUN_BIT] && mode_ok;
	// Only the chosen source counts; the other pin may toggle freely
	assign tick = ((src_reg == CWU_SRC_SLOW) && slow_tick) || ((src_reg == CWU_SRC_FAST) && fast_tick);

	// Upper byte only; low compare byte ignored, so each step is 256 source periods
	// Compare byte is read live: lowering it mid-count can miss the match until wrap
	assign match = tick && (count_next[15:8] == period_compare_high_i)
		&& (count_next[7:0] == `CWU_LOW_BYTE_ZERO);

	// Next count value on a source tick
	assign count_next = count_reg + `CWU_COUNT_ONE;

	// Sequencer: idle until run, count, return to idle when run drops
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			CWU_ST_IDLE:
			begin
				if (run_bit)
					state_next = CWU_ST_COUNT;
			end
			CWU_ST_COUNT:
			begin
				if (!run_bit)
					state_next = CWU_ST_IDLE;
				else if (match)
					state_next = CWU_ST_DONE;
			end
			CWU_ST_DONE:
			begin
				// Keeps counting after a match until software stops it
				if (!run_bit)
					state_next = CWU_ST_IDLE;
				else
					state_next = CWU_ST_COUNT;
			end
			default:
				state_next = CWU_ST_IDLE;
		endcase
	end

	// State register
	// Spare code 11 cannot be reached; the default branch would return it to idle
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state_reg <= CWU_ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Counter: cleared on stop and on match so a restart times a full period
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			count_reg <= `CWU_COUNT_RESET;
		// Stop wins over a match that lands in the same cycle
		else if (!run_bit)
			count_reg <= `CWU_COUNT_RESET;
		else if (match)
			count_reg <= `CWU_COUNT_RESET;
		else if (tick)
			count_reg <= count_next;
	end

	// Interrupt request, one clk_i cycle per match
	// Gated by the run bit, so a stopped counter never leaves a late request
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			irq_reg <= 1'b0;
		else
			irq_reg <= run_bit && match;
	end

	// Running flag from a flop, in step with the state register
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			running_reg <= 1'b0;
		else
			running_reg <= (state_next != CWU_ST_IDLE);
	end

	// Registered values straight to the ports
	assign upper_timer_irq_o = irq_reg;
	assign count_o = count_reg;
	assign running_o = running_reg;
	assign source_o = src_reg;

	// System clock select and oscillator enables at their bit positions
	assign sys_clk_low_sel_o = sys_reg[`CWU_SYS_CLK_SEL_BIT];
	assign low_osc_enable_o = sys_reg[`CWU_SYS_SLOW_OSC_EN_BIT];
	assign high_osc_enable_o = sys_reg[`CWU_SYS_FAST_OSC_EN_BIT];

	// Flip-flop initial values passed out; no pulse logic in this mode
	assign upper_flipflop_init_o = upper_reg[`CWU_UPPER_FF_INIT_BIT];
	assign lower_flipflop_init_o = lower_reg[`CWU_LOWER_FF_INIT_BIT];

endmodule // cwu_warmup_counter

`default_nettype wire

// file: core/cwu_regs.svh
// Bit positions, field codes and reset values of the warm-up counter controls.
// Assumes it is included by the package and the design modules; holds definitions only.
`ifndef CWU_REGS_SVH
`define CWU_REGS_SVH

// Upper timer control fields
`define CWU_UPPER_RUN_BIT 3
`define CWU_UPPER_MODE_MSB 2
`define CWU_UPPER_MODE_LSB 0
`define CWU_UPPER_MODE_WARMUP 3'h5
`define CWU_UPPER_FF_INIT_BIT 7
`define CWU_UPPER_CTRL_RESET 8'h00

// Lower timer control fields
`define CWU_LOWER_CLK_MSB 6
`define CWU_LOWER_CLK_LSB 4
`define CWU_LOWER_CLK_SLOW 3'h4
`define CWU_LOWER_CLK_FAST 3'h6
`define CWU_LOWER_MODE_MSB 2
`define CWU_LOWER_MODE_LSB 0
`define CWU_LOWER_MODE_CASCADE 3'h3
`define CWU_LOWER_FF_INIT_BIT 7
`define CWU_LOWER_CTRL_RESET 8'h00

// System control register two fields
`define CWU_SYS_CLK_SEL_BIT 5
`define CWU_SYS_SLOW_OSC_EN_BIT 6
`define CWU_SYS_FAST_OSC_EN_BIT 7
`define CWU_SYS_CTRL_RESET 8'h80

// Compare and counter reset values
`define CWU_COMPARE_RESET 8'hFF
`define CWU_COUNT_RESET 16'h0000
`define CWU_LOW_BYTE_ZERO 8'h00
`define CWU_COUNT_ONE 16'h0001

// Source periods per step of the compare upper byte
`define CWU_PERIODS_PER_STEP 256

`endif

// file: core/cwu_pkg.sv
// Types shared by the warm-up counter modules.
// Assumes cwu_regs.svh is on the include path.
`include "cwu_regs.svh"

package cwu_pkg;

	// Count source chosen by the lower timer control
	typedef enum logic [1:0]
	{
		CWU_SRC_NONE = 2'b00,
		CWU_SRC_SLOW = 2'b01,
		CWU_SRC_FAST = 2'b10
	} cwu_src_t;

	// Counter sequencing
	typedef enum logic [1:0]
	{
		CWU_ST_IDLE = 2'b00,
		CWU_ST_COUNT = 2'b01,
		CWU_ST_DONE = 2'b10
	} cwu_state_t;

endpackage

// file: core/cwu_edge_sync.sv
// Three-stage pin synchroniser with a rising-edge pulse on the stable level.
// Assumes the input is asynchronous to clk_i and at no more than a quarter of its rate.
`timescale 1ns/1ns
`default_nettype none

module cwu_edge_sync
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic pin_i,
	output logic rise_o
);
	import cwu_pkg::*;

	logic meta_reg;
	logic sync2_reg;
	logic sync3_reg;
	logic stable_reg;

	// First stage feeds only the second
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= pin_i;
			sync2_reg <= meta_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// Level only counts once stages two and three agree, filters one-cycle glitches
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			stable_reg <= 1'b0;
		else if (sync2_reg == sync3_reg)
			stable_reg <= sync3_reg;
	end

	// Pulse in the cycle the agreed level goes high
	assign rise_o = (sync2_reg == sync3_reg) && sync3_reg && !stable_reg;

endmodule // cwu_edge_sync

`default_nettype wire

// file: sim/cwu_warmup_counter_checker.sv
// Port-level assertions for the warm-up counter.
// Assumes binding onto cwu_warmup_counter; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module cwu_warmup_counter_checker
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] upper_timer_control_i,
	input wire logic [7:0] lower_timer_control_i,
	input wire logic [7:0] period_compare_high_i,
	input wire logic [7:0] system_control_reg_two_i,
	input wire logic upper_timer_irq_o,
	input wire logic [15:0] count_o,
	input wire logic running_o,
	input wire cwu_pkg::cwu_src_t source_o,
	input wire logic sys_clk_low_sel_o,
	input wire logic low_osc_enable_o,
	input wire logic high_osc_enable_o,
	input wire logic upper_flipflop_init_o,
	input wire logic lower_flipflop_init_o
);
	import cwu_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// Run bit rising while warm-up mode is chosen
	sequence s_start;
		$rose(upper_timer_control_i[3]) && upper_timer_control_i[2:0] == 3'h5;
	endsequence
	// Lower byte held at a valid cascade code for three edges
	sequence s_src;
		(lower_timer_control_i == 8'h43 || lower_timer_control_i == 8'h63) && $stable(lower_timer_control_i) [*2];
	endsequence
	property p_start;
		s_start |-> ##[1:3] running_o;
	endproperty
	a_start: assert property (p_start) else $error("counter not started");
	property p_stop;
		$fell(upper_timer_control_i[3]) |-> ##[1:3] (count_o == 16'h0000 && !running_o);
	endproperty
	a_stop: assert property (p_stop) else $error("counter not stopped");
	property p_pulse;
		upper_timer_irq_o |=> !upper_timer_irq_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("request too long");
	property p_clear;
		upper_timer_irq_o |-> count_o == 16'h0000 && $past(count_o) == {$past(period_compare_high_i), 8'h00} - 16'h0001;
	endproperty
	a_clear: assert property (p_clear) else $error("count not cleared");
	property p_step;
		count_o != $past(count_o) |-> count_o == $past(count_o) + 16'h0001 || count_o == 16'h0000;
	endproperty
	a_step: assert property (p_step) else $error("count skipped");
	// Cleared on the match, so the upper byte never reaches the compare byte
	property p_bound;
		running_o && period_compare_high_i != 8'h00 |-> count_o[15:8] < period_compare_high_i;
	endproperty
	a_bound: assert property (p_bound) else $error("match missed");
	property p_sys;
		$past(arst_n_i) |-> {high_osc_enable_o, low_osc_enable_o, sys_clk_low_sel_o} == $past(system_control_reg_two_i[7:5]);
	endproperty
	a_sys: assert property (p_sys) else $error("system bits wrong");
	property p_ff;
		$past(arst_n_i) |-> {upper_flipflop_init_o, lower_flipflop_init_o} == $past({upper_timer_control_i[7], lower_timer_control_i[7]});
	endproperty
	a_ff: assert property (p_ff) else $error("flip-flop init wrong");
	property p_src;
		s_src |-> source_o == (lower_timer_control_i[5] ? CWU_SRC_FAST : CWU_SRC_SLOW);
	endproperty
	a_src: assert property (p_src) else $error("source wrong");
endmodule // cwu_warmup_counter_checker
bind cwu_warmup_counter cwu_warmup_counter_checker u_chk (.*);
`default_nettype wire

// file: sim/cwu_warmup_counter_tb.sv
// Self-checking bench: control bytes and source pins driven on falling edges.
// Assumes the checker is compiled too; ticks are sped up, only their count matters.
`timescale 1ns/1ns
`default_nettype none
`include "cwu_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: mismatch", $time); end end
module cwu_warmup_counter_tb;
	import cwu_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n = 1'b0;
	logic lf = 1'b0;
	logic hf = 1'b0;
	logic [7:0] up = 8'h00;
	logic [7:0] lo = 8'h00;
	logic [7:0] ch = 8'hFF;
	logic [7:0] sys = `CWU_SYS_CTRL_RESET;
	logic irq, run, sel, sen, fen, uff, lff;
	logic [15:0] cnt;
	cwu_src_t src;
	int failures = 0;
	int comparisons = 0;
	int irqs = 0;
	cwu_warmup_counter u_dut (.clk_i(clk_i), .arst_n_i(rst_n), .low_freq_clock_i(lf), .high_freq_clock_i(hf),
		.upper_timer_control_i(up), .lower_timer_control_i(lo), .period_compare_high_i(ch),
		.period_compare_low_i(8'h5A), .system_control_reg_two_i(sys), .upper_timer_irq_o(irq), .count_o(cnt),
		.running_o(run), .source_o(src), .sys_clk_low_sel_o(sel), .low_osc_enable_o(sen),
		.high_osc_enable_o(fen), .upper_flipflop_init_o(uff), .lower_flipflop_init_o(lff));
	// Clock and one-cycle request counting
	initial forever #25 clk_i = ~clk_i;
	always @(posedge clk_i) if (irq === 1'b1) irqs++;
	// Control bytes, then enough spacing for the two-stage source path
	task automatic wr(input logic [7:0] s, input logic [7:0] u, input logic [7:0] l, input logic [7:0] h);
		@(negedge clk_i);
		sys = s;
		up = u;
		lo = l;
		ch = h;
		repeat (4) @(negedge clk_i);
	endtask
	// High half of four cycles keeps the fast pin visible through the synchroniser
	task automatic tick(input logic fast, input int n);
		repeat (n)
		begin
			repeat (4) @(negedge clk_i);
			lf = !fast;
			hf = fast;
			repeat (4) @(negedge clk_i);
			lf = 1'b0;
			hf = 1'b0;
		end
		repeat (8) @(negedge clk_i);
	endtask
	// One warm-up: silent one tick short, request on the last, again a period later
	task automatic warm(input logic fast, input logic [7:0] s, input logic [7:0] h);
		int n;
		n = h * `CWU_PERIODS_PER_STEP;
		wr(s, 8'h05, fast ? 8'h63 : 8'h43, h);
		`CHK(src, fast ? CWU_SRC_FAST : CWU_SRC_SLOW)
		irqs = 0;
		wr(s, 8'h0D, lo, h);
		`CHK(run, 1'b1)
		tick(fast, n - 1);
		`CHK(irqs, 0)
		tick(fast, 1);
		`CHK(irqs, 1)
		`CHK(cnt, 16'h0000)
		tick(fast, n);
		`CHK(irqs, 2)
		wr(s, 8'h05, lo, h);
		`CHK({run, cnt}, 17'h00000)
	endtask
	// Counts, then the verdict
	task automatic summarize();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Whole run is near 12500 cycles
	initial
	begin
		repeat (30000) @(posedge clk_i);
		failures++;
		summarize();
	end
	// Main sequence
	initial
	begin
		repeat (4) @(negedge clk_i);
		rst_n = 1'b1;
		`CHK({irq, cnt, run, src}, {1'b0, 16'h0000, 1'b0, CWU_SRC_NONE})
		`CHK({sel, sen, fen, uff, lff}, 5'b00100)
		$display("end of reset test");
		warm(1'b0, 8'hC0, 8'h01);
		wr(8'hE0, 8'h05, lo, ch);
		`CHK({fen, sen, sel}, 3'b111)
		wr(8'h60, 8'h05, lo, ch);
		`CHK({fen, sen, sel}, 3'b011)
		$display("end of slow test");
		warm(1'b1, 8'hE0, 8'h02);
		wr(8'hC0, 8'h85, 8'hE3, ch);
		`CHK({fen, sen, sel, uff, lff}, 5'b11011)
		wr(8'h80, 8'h05, 8'h63, ch);
		`CHK({fen, sen, sel, uff, lff}, 5'b10000)
		$display("end of fast test");
		wr(8'h80, 8'h0C, 8'h63, 8'h01);
		`CHK(run, 1'b0)
		tick(1'b1, 2);
		`CHK(cnt, 16'h0000)
		wr(8'h80, 8'h0D, 8'h53, 8'h01);
		`CHK({run, src}, {1'b1, CWU_SRC_NONE})
		tick(1'b1, 2);
		`CHK(cnt, 16'h0000)
		wr(8'h80, 8'h05, 8'h63, 8'h01);
		$display("end of refusal test");
		summarize();
	end
endmodule // cwu_warmup_counter_tb
`default_nettype wire
